// ==== dpm_pkg.sv ====
package dpm_pkg;

  // ****************************************
  // Register map of the controller
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;

  // CTRL fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 3;
  localparam int CTRL_LOW_LANE = 4;
  localparam int CTRL_HIGH_LANE = 5;

  // STATUS fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_CONTENTION_SEEN = 2;
  localparam int ST_CONTENTION = 3;
  localparam int ST_MSG_FLAG = 4;
  localparam int ST_OWNED_LSB = 8;

  // Operation codes; zero aborts a token poll
  localparam logic [2:0] OP_ABORT = 3'h0;
  localparam logic [2:0] OP_MEM_READ = 3'h1;
  localparam logic [2:0] OP_MEM_WRITE = 3'h2;
  localparam logic [2:0] OP_TOKEN_REQ = 3'h3;
  localparam logic [2:0] OP_TOKEN_REL = 3'h4;
  localparam logic [2:0] OP_TOKEN_READ = 3'h5;

  localparam int TOKEN_COUNT = 8;
  localparam int TOKEN_ADDR_W = 3;

  // ****************************************
  // Timing, in ns and in 10 ns cycles
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACCESS_NS = 25;
  localparam int WRITE_PULSE_NS = 20;
  localparam int TOKEN_GAP_NS = 10;
  localparam int FLAG_SETTLE_NS = 20;
  localparam int FLOWTHROUGH_NS = 30;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOKEN_GAP_CYC = (TOKEN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (FLAG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOW_CYC = (FLOWTHROUGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_WRITE, S_GAP, S_READ} dpm_state_t;

endpackage

// ==== dpm_port_ctrl.sv ====
// Contract
// - Token reads assert token select and output enable, memory select stays high.
// - Memory reads wait the flowthrough delay after the data appears at the other port.
// - Memory writes wait until the contention input has settled and released.
// - Token request writes zero, then releases strobes for the gap before readback.
// - Readback zero means owned, one means keep polling; release by writing one.
module dpm_port_ctrl
  import dpm_pkg::*;
#(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] swAddr,
  input wire logic [31:0] swWdata,
  input wire logic swWr,
  input wire logic swRd,
  output logic [31:0] swRdata,
  output logic memSelN,
  output logic tokenSelN,
  output logic rwN,
  output logic outEnN,
  output logic highLaneSelN,
  output logic lowLaneSelN,
  output logic [ADDR_W-1:0] pinAddr,
  output logic [DATA_W-1:0] pinDataOut,
  output logic pinDataOe,
  input wire logic [DATA_W-1:0] pinDataIn,
  input wire logic contentionN,
  input wire logic msgFlagN
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic busyMeta_q, busySync_q, msgMeta_q, msgSync_q;
  logic [DATA_W-1:0] dataMeta_q, dataSync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      busyMeta_q <= 1'b0;
      busySync_q <= 1'b0;
      msgMeta_q <= 1'b0;
      msgSync_q <= 1'b0;
      dataMeta_q <= '0;
      dataSync_q <= '0;
    end else begin
      busyMeta_q <= ~contentionN;
      busySync_q <= busyMeta_q;
      msgMeta_q <= ~msgFlagN;
      msgSync_q <= msgMeta_q;
      dataMeta_q <= pinDataIn;
      dataSync_q <= dataMeta_q;
    end
  end

  // ****************************************
  // Software registers and decode
  // ****************************************
  dpm_state_t state_q;
  logic [CTRL_OP_W-1:0] op_q;
  logic highLane_q, lowLane_q, done_q, contSeen_q, abort_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q, rdata_q;
  logic [TOKEN_COUNT-1:0] owned_q;
  logic [CNT_W-1:0] cnt_q;

  wire idle = (state_q == S_IDLE);
  wire ctrlWr = swWr && (swAddr == REG_CTRL);
  wire [CTRL_OP_W-1:0] newOp = swWdata[CTRL_OP_LSB +: CTRL_OP_W];
  wire start = ctrlWr && idle && (newOp != OP_ABORT);
  wire isTokenOp = (op_q == OP_TOKEN_REQ) || (op_q == OP_TOKEN_REL) || (op_q == OP_TOKEN_READ);
  wire [TOKEN_ADDR_W-1:0] tokenIdx = addr_q[TOKEN_ADDR_W-1:0];
  wire cntZero = (cnt_q == '0);

  wire [31:0] statusWord = {{(24 - TOKEN_COUNT){1'b0}}, owned_q, 3'h0, msgSync_q,
                            busySync_q, contSeen_q, done_q, ~idle};
  wire [31:0] ctrlWord = {26'h0, highLane_q, lowLane_q, 1'b0, op_q};
  wire [31:0] readMux =
    (swAddr == REG_CTRL) ? ctrlWord :
    (swAddr == REG_ADDR) ? 32'(addr_q) :
    (swAddr == REG_WDATA) ? 32'(wdata_q) :
    (swAddr == REG_STATUS) ? statusWord :
    (swAddr == REG_RDATA) ? 32'(rdata_q) : 32'h0;

  logic [31:0] swRdata_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      swRdata_q <= 32'h0;
    end else if (swRd) begin
      swRdata_q <= readMux;
    end
  end
  assign swRdata = swRdata_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q <= '0;
      wdata_q <= '0;
    end else if (swWr && idle) begin
      if (swAddr == REG_ADDR) begin
        addr_q <= swWdata[ADDR_W-1:0];
      end
      if (swAddr == REG_WDATA) begin
        wdata_q <= swWdata[DATA_W-1:0];
      end
    end
  end

  // ****************************************
  // Port sequencer
  // ****************************************
  // Pin outputs are all registered so the strobes never glitch at the device.
  logic memSelN_q, tokenSelN_q, rwN_q, outEnN_q, hiN_q, loN_q, dataOe_q;
  logic [DATA_W-1:0] dataOut_q;
  logic [ADDR_W-1:0] pinAddr_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      op_q <= OP_ABORT;
      highLane_q <= 1'b0;
      lowLane_q <= 1'b0;
      cnt_q <= '0;
      done_q <= 1'b0;
      contSeen_q <= 1'b0;
      abort_q <= 1'b0;
      owned_q <= '0;
      rdata_q <= '0;
      memSelN_q <= 1'b1;
      tokenSelN_q <= 1'b1;
      rwN_q <= 1'b1;
      outEnN_q <= 1'b1;
      hiN_q <= 1'b1;
      loN_q <= 1'b1;
      dataOe_q <= 1'b0;
      dataOut_q <= '0;
      pinAddr_q <= '0;
    end else begin
      if (ctrlWr && !idle && (newOp == OP_ABORT)) begin
        abort_q <= 1'b1;
      end
      if (!idle && busySync_q && !isTokenOp) begin
        contSeen_q <= 1'b1;
      end
      case (state_q)
        S_IDLE: begin
          if (start) begin
            op_q <= newOp;
            highLane_q <= swWdata[CTRL_HIGH_LANE];
            lowLane_q <= swWdata[CTRL_LOW_LANE];
            done_q <= 1'b0;
            contSeen_q <= 1'b0;
            abort_q <= 1'b0;
            // Data pins let go on the same edge that a read turns the device outputs on
            dataOe_q <= 1'b0;
            pinAddr_q <= addr_q;
            rwN_q <= 1'b1;
            if (newOp == OP_MEM_READ || newOp == OP_MEM_WRITE) begin
              memSelN_q <= 1'b0;
              hiN_q <= ~swWdata[CTRL_HIGH_LANE];
              loN_q <= ~swWdata[CTRL_LOW_LANE];
            end else begin
              // Token select low with memory select held high
              tokenSelN_q <= 1'b0;
              hiN_q <= 1'b0;
              loN_q <= 1'b0;
            end
            if (newOp == OP_MEM_READ) begin
              outEnN_q <= 1'b0;
              cnt_q <= CNT_W'(ACCESS_CYC + FLOW_CYC - 1);
              state_q <= S_READ;
            end else if (newOp == OP_TOKEN_READ) begin
              outEnN_q <= 1'b0;
              cnt_q <= CNT_W'(ACCESS_CYC - 1);
              state_q <= S_READ;
            end else if (newOp == OP_MEM_WRITE) begin
              cnt_q <= CNT_W'(SETTLE_CYC - 1);
              state_q <= S_SETTLE;
            end else begin
              cnt_q <= '0;
              state_q <= S_SETTLE;
            end
          end
        end
        S_SETTLE: begin
          if (!cntZero) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (isTokenOp || !busySync_q) begin
            rwN_q <= 1'b0;
            dataOe_q <= 1'b1;
            if (op_q == OP_TOKEN_REQ) begin
              dataOut_q <= '0;
            end else if (op_q == OP_TOKEN_REL) begin
              dataOut_q <= DATA_W'(1);
            end else begin
              dataOut_q <= wdata_q;
            end
            cnt_q <= CNT_W'(WRITE_CYC - 1);
            state_q <= S_WRITE;
          end
        end
        S_WRITE: begin
          if (!cntZero) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            // Write strobe and selects rise on the same edge; data stays driven until the next operation starts, one more cycle only for a token request
            rwN_q <= 1'b1;
            memSelN_q <= 1'b1;
            tokenSelN_q <= 1'b1;
            if (op_q == OP_TOKEN_REQ) begin
              cnt_q <= CNT_W'(TOKEN_GAP_CYC - 1);
              state_q <= S_GAP;
            end else begin
              if (op_q == OP_TOKEN_REL) begin
                owned_q[tokenIdx] <= 1'b0;
              end
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        end
        S_GAP: begin
          dataOe_q <= 1'b0;
          if (!cntZero) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (abort_q) begin
            // Abort is taken after the gap so the cancel write keeps recovery time
            // Pending zero is withdrawn, else a later release would hand us the token
            op_q <= OP_TOKEN_REL;
            tokenSelN_q <= 1'b0;
            cnt_q <= '0;
            state_q <= S_SETTLE;
          end else begin
            tokenSelN_q <= 1'b0;
            outEnN_q <= 1'b0;
            cnt_q <= CNT_W'(ACCESS_CYC - 1);
            state_q <= S_READ;
          end
        end
        S_READ: begin
          if (!cntZero) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            // Synchroniser adds two cycles that the access count does not include; the value is the pins two cycles before this edge
            rdata_q <= dataSync_q;
            memSelN_q <= 1'b1;
            tokenSelN_q <= 1'b1;
            outEnN_q <= 1'b1;
            if (isTokenOp) begin
              owned_q[tokenIdx] <= ~dataSync_q[0];
            end
            // A token request miss goes to the gap; an abort is handled there
            if (op_q == OP_TOKEN_REQ && dataSync_q[0]) begin
              cnt_q <= CNT_W'(TOKEN_GAP_CYC - 1);
              state_q <= S_GAP;
            end else begin
              hiN_q <= 1'b1;
              loN_q <= 1'b1;
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  assign memSelN = memSelN_q;
  assign tokenSelN = tokenSelN_q;
  assign rwN = rwN_q;
  assign outEnN = outEnN_q;
  assign highLaneSelN = hiN_q;
  assign lowLaneSelN = loN_q;
  assign pinAddr = pinAddr_q;
  assign pinDataOut = dataOut_q;
  assign pinDataOe = dataOe_q;

endmodule

// ==== dpm_dev_model.sv ====
// ****
// Device model, one port
// ****
module dpm_dev_model (
  input wire logic clk,
  input wire logic memSelN,
  input wire logic tokenSelN,
  input wire logic rwN,
  input wire logic outEnN,
  input wire logic highLaneSelN,
  input wire logic lowLaneSelN,
  input wire logic [15:0] pinAddr,
  input wire logic [17:0] pinDataOut,
  output logic [17:0] devData,
  output logic contentionN,
  output logic msgFlagN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] mem [0:65535];
  logic [17:0] noise = 18'h2AAAA;
  logic [7:0] own [2] = '{8'h00, 8'h00};
  logic [7:0] pend [2] = '{8'h00, 8'h00};
  logic ourFlag = 1'b0;
  logic otherFlag = 1'b0;
  logic contend = 1'b0;
  logic tokQ = 1'b1;
  logic armed = 1'b0;
  logic armTok;
  logic [17:0] armMask;
  logic [17:0] laneMask;
  assign contentionN = ~contend;
  assign msgFlagN = ~ourFlag;
  assign laneMask = {{9{!highLaneSelN}}, {9{!lowLaneSelN}}};
  // Undriven lines toggle so a late sample cannot pass by luck
  always @(posedge clk) noise <= ~noise;
  assign devData = (!outEnN && !tokenSelN) ? {18{tokQ}} :
    (!outEnN && !memSelN) ? (mem[pinAddr] & laneMask) | (noise & ~laneMask) : noise;
  task automatic tokWr(input int s, input logic [2:0] i, input logic b);
    if (!b && own[1-s][i]) pend[s][i] = 1'b1;
    else if (!b) own[s][i] = 1'b1;
    else if (own[s][i]) begin
      own[s][i] = 1'b0;
      own[1-s][i] = pend[1-s][i];
      pend[1-s][i] = 1'b0;
    end else pend[s][i] = 1'b0;
  endtask
  always @(negedge rwN) begin
    armed = 1'b1;
    armTok = !tokenSelN;
    armMask = laneMask;
  end
  always @(posedge rwN or posedge memSelN or posedge tokenSelN) begin
    if (armed) begin
      armed = 1'b0;
      if (armTok) tokWr(0, pinAddr[2:0], pinDataOut[0]);
      else begin
        mem[pinAddr] = (pinDataOut & armMask) | (mem[pinAddr] & ~armMask);
        if (pinAddr == 16'hFFFF && contentionN) otherFlag = 1'b1;
      end
    end
  end
  // Value frozen at access start so a far-side write cannot disturb it
  always @(negedge outEnN) begin
    #1;
    tokQ = !own[0][pinAddr[2:0]];
    if (!memSelN && pinAddr == 16'hFFFE && contentionN) ourFlag = 1'b0;
  end
endmodule

// ==== dpm_port_ctrl_chk.sv ====
// ****
// Pin sequencing checks
// ****
module dpm_port_ctrl_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic memSelN,
  input wire logic tokenSelN,
  input wire logic rwN,
  input wire logic outEnN,
  input wire logic pinDataOe,
  input wire logic contentionN
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_body;
    (!rwN && !memSelN && pinDataOe) [*2] ##1 (rwN && memSelN);
  endsequence
  sequence s_tok_body;
    (!rwN && !tokenSelN && pinDataOe) [*2] ##1 (rwN && tokenSelN && outEnN);
  endsequence
  property p_tok_rd;
    (!tokenSelN && !outEnN) |-> (memSelN && rwN);
  endproperty
  a_tok_rd: assert property (p_tok_rd) else $error("token read with memory select");
  property p_sel_excl;
    !tokenSelN |-> memSelN;
  endproperty
  a_sel_excl: assert property (p_sel_excl) else $error("both selects low");
  property p_no_fight;
    !outEnN |-> !pinDataOe;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("data driven during read");
  property p_settle;
    $fell(memSelN) |-> rwN [*2];
  endproperty
  a_settle: assert property (p_settle) else $error("write before settle");
  property p_cont;
    (!contentionN) [*5] |-> !($fell(rwN) && !memSelN);
  endproperty
  a_cont: assert property (p_cont) else $error("write during contention");
  property p_wr_pulse;
    ($fell(rwN) && !memSelN) |-> s_wr_body;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("bad write pulse");
  property p_rd_hold;
    ($fell(outEnN) && !memSelN) |-> (!outEnN && !memSelN && rwN) [*6] ##1 outEnN;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read too short");
  property p_tok_wr;
    ($fell(rwN) && !tokenSelN) |-> s_tok_body;
  endproperty
  a_tok_wr: assert property (p_tok_wr) else $error("no gap after token write");
  property p_rst_idle;
    $fell(rst) |-> (memSelN && tokenSelN && rwN && outEnN && !pinDataOe);
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins active after reset");
endmodule

// ==== tb_top.sv ====
module tb_top
  import dpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Bench
  // ****
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] swAddr = 8'h00;
  logic [31:0] swWdata = 32'h0;
  logic swWr = 1'b0;
  logic swRd = 1'b0;
  logic [31:0] swRdata, st;
  logic memSelN, tokenSelN, rwN, outEnN, highLaneSelN, lowLaneSelN, pinDataOe;
  logic contentionN, msgFlagN;
  logic [15:0] pinAddr;
  logic [17:0] pinDataOut, devData;
  int errCount = 0;
  int totalChecks = 0;
  always #5 clk = ~clk;
  dpm_port_ctrl dut (.clk(clk), .rst(rst), .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr),
    .swRd(swRd), .swRdata(swRdata), .memSelN(memSelN), .tokenSelN(tokenSelN), .rwN(rwN),
    .outEnN(outEnN), .highLaneSelN(highLaneSelN), .lowLaneSelN(lowLaneSelN),
    .pinAddr(pinAddr), .pinDataOut(pinDataOut), .pinDataOe(pinDataOe), .pinDataIn(devData),
    .contentionN(contentionN), .msgFlagN(msgFlagN));
  dpm_dev_model u_dev (.clk(clk), .memSelN(memSelN), .tokenSelN(tokenSelN), .rwN(rwN),
    .outEnN(outEnN), .highLaneSelN(highLaneSelN), .lowLaneSelN(lowLaneSelN),
    .pinAddr(pinAddr), .pinDataOut(pinDataOut), .devData(devData),
    .contentionN(contentionN), .msgFlagN(msgFlagN));
  task automatic test_done();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Trailing idle cycle keeps back-to-back calls off the same strobe step
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    swAddr <= a;
    swWdata <= d;
    swWr <= 1'b1;
    @(posedge clk);
    swWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic regRd(input logic [7:0] a, output logic [31:0] d);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge clk);
    swRd <= 1'b0;
    @(posedge clk);
    d = swRdata;
  endtask
  task automatic waitDone();
    for (int k = 0; k < 100; k++) begin
      regRd(REG_STATUS, st);
      if (st[ST_DONE]) break;
    end
    chk(st[ST_DONE], 32'h1);
  endtask
  task automatic doOp(input logic [2:0] op, input logic [15:0] a, input logic [17:0] d,
      input logic [1:0] ln = 2'b11);
    regWr(REG_ADDR, {16'h0, a});
    regWr(REG_WDATA, {14'h0, d});
    regWr(REG_CTRL, {26'h0, ln, 1'b0, op});
    waitDone();
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    regRd(REG_STATUS, st);
    chk(st, 32'h0);
    regRd(8'h14, st);
    chk(st, 32'h0);
    doOp(OP_MEM_WRITE, 16'h0010, 18'h01234);
    doOp(OP_MEM_WRITE, 16'h0010, 18'h3FFFF, 2'b01);
    doOp(OP_MEM_WRITE, 16'h0010, 18'h00000, 2'b10);
    doOp(OP_MEM_READ, 16'h0010, 18'h0);
    regRd(REG_RDATA, st);
    chk(st, 32'h001FF);
    u_dev.ourFlag <= 1'b1;
    doOp(OP_MEM_READ, 16'hFFFF, 18'h0);
    regRd(REG_STATUS, st);
    chk(st[ST_MSG_FLAG], 32'h1);
    u_dev.contend <= 1'b1;
    doOp(OP_MEM_READ, 16'hFFFE, 18'h0);
    regRd(REG_STATUS, st);
    chk({st[ST_CONTENTION], st[ST_MSG_FLAG]}, 32'h3);
    regWr(REG_ADDR, 32'hFFFF);
    regWr(REG_WDATA, 32'h5A);
    regWr(REG_CTRL, {26'h0, 2'b11, 1'b0, OP_MEM_WRITE});
    repeat (20) @(posedge clk);
    regRd(REG_STATUS, st);
    chk({st[ST_BUSY], u_dev.otherFlag}, 32'h2);
    u_dev.contend <= 1'b0;
    waitDone();
    chk({st[ST_CONTENTION_SEEN], u_dev.otherFlag}, 32'h3);
    doOp(OP_MEM_READ, 16'hFFFE, 18'h0);
    regRd(REG_STATUS, st);
    chk(st[ST_MSG_FLAG], 32'h0);
    for (int i = 0; i < TOKEN_COUNT; i++) doOp(OP_TOKEN_REQ, 16'hFFF8 | 16'(i), 18'h0);
    regRd(REG_STATUS, st);
    chk({st[15:8], u_dev.own[1]}, 32'hFF00);
    u_dev.tokWr(1, 3'd0, 1'b1);
    doOp(OP_TOKEN_READ, 16'h0, 18'h0);
    regRd(REG_RDATA, st);
    chk(st, 32'h0);
    u_dev.tokWr(1, 3'd2, 1'b0);
    doOp(OP_TOKEN_REL, 16'h2, 18'h0);
    doOp(OP_TOKEN_READ, 16'h2, 18'h0);
    regRd(REG_RDATA, st);
    chk(st, 32'h3FFFF);
    regWr(REG_CTRL, {26'h0, 2'b11, 1'b0, OP_TOKEN_REQ});
    repeat (30) @(posedge clk);
    regRd(REG_STATUS, st);
    chk({st[ST_BUSY], st[15:8]}, 32'h1FB);
    u_dev.tokWr(1, 3'd2, 1'b1);
    waitDone();
    chk(st[15:8], 32'hFF);
    for (int i = 0; i < TOKEN_COUNT; i++) doOp(OP_TOKEN_REL, 16'(i), 18'h0);
    doOp(OP_TOKEN_READ, 16'h5, 18'h0);
    regRd(REG_RDATA, st);
    chk(st, 32'h3FFFF);
    regRd(REG_STATUS, st);
    chk(st[15:8], 32'h0);
    u_dev.tokWr(1, 3'd3, 1'b0);
    regWr(REG_ADDR, 32'h3);
    regWr(REG_CTRL, {26'h0, 2'b11, 1'b0, OP_TOKEN_REQ});
    repeat (20) @(posedge clk);
    regWr(REG_CTRL, 32'h0);
    waitDone();
    u_dev.tokWr(1, 3'd3, 1'b1);
    chk({st[ST_BUSY], st[ST_OWNED_LSB + 3], u_dev.pend[0][3], u_dev.own[0][3]}, 32'h0);
    regRd(REG_ADDR, st);
    chk(st, 32'h3);
    test_done();
  end
  initial begin
    repeat (40000) @(posedge clk);
    errCount++;
    test_done();
  end
endmodule
bind dpm_port_ctrl dpm_port_ctrl_chk u_chk (.clk(clk), .rst(rst), .memSelN(memSelN),
  .tokenSelN(tokenSelN), .rwN(rwN), .outEnN(outEnN), .pinDataOe(pinDataOe),
  .contentionN(contentionN));
